// ==== verilog/pinmux_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  pin function control block. Assumes inclusion by bare name.
*/
`ifndef PINMUX_REGS_SVH
`define PINMUX_REGS_SVH

`define NUM_PINS 7
`define CFG_W 8

// Byte offsets; pin configuration i sits at OFS_PIN_CFG0 + 4*i
`define OFS_PIN_CFG0 6'h00
`define OFS_STAT_A 6'h1C
`define OFS_STAT_B 6'h20
`define OFS_MAX_POWER 6'h24
`define OFS_PIN_IN 6'h28
`define OFS_USB_STATE 6'h2C

// Pin configuration fields
`define CFG_FUNC_LSB 0
`define CFG_FUNC_MSB 1
`define CFG_DIR 2
`define CFG_OUT 3
`define CFG_OD 4
`define CFG_PU 5
`define CFG_PD 6

`define FN_GPIO 2'h0
`define FN_ALT1 2'h1
`define FN_ALT2 2'h2

// Status output configuration fields
`define ST_COND_LSB 0
`define ST_COND_MSB 1
`define ST_ACT_HIGH 2
`define ST_PUSH_PULL 3

`define COND_BUS_RESET 2'h0
`define COND_SUSPEND 2'h1
`define COND_UNSAFE 2'h2

// Reset values
`define RST_PIN_RTS 8'h11
`define RST_PIN_CTS 8'h21
`define RST_PIN_RS485 8'h01
`define RST_PIN_TXT 8'h01
`define RST_PIN_RXT 8'h01
`define RST_PIN_CD 8'h20
`define RST_PIN_RI 8'h20
`define RST_STAT_A 8'h05
`define RST_STAT_B 8'h01
`define RST_MAX_POWER 8'h32
`define ONE_UNIT_LOAD 8'h32

// Timing
`define MCLK_HZ 100000000
`define ACT_TOGGLE_HZ 10
`define ACT_HALF_CYCLES (`MCLK_HZ / (2 * `ACT_TOGGLE_HZ))

`endif

// ==== verilog/pinmux_pkg.sv ====
/*
  Types shared by the pin function control modules.
  Assumes pinmux_regs.svh is on the include path.
*/
`default_nettype none
`include "pinmux_regs.svh"

package pinmux_pkg;
  typedef logic [`CFG_W-1:0] cfg_t;
  typedef logic [`NUM_PINS-1:0] pin_vec_t;
  typedef enum logic [0:0] {ACT_IDLE, ACT_BLINK} act_state_t;
endpackage

`default_nettype wire

// ==== verilog/act_if.sv ====
/*
  Carrier between the pin control top and an activity blinker.
  Assumes both ends share i_mclk.
*/
`default_nettype none

interface act_if;
  logic busy;
  logic ce;
  logic level;
  modport src (output busy, output ce, input level);
  modport blink (input busy, input ce, output level);
endinterface

`default_nettype wire

// ==== verilog/activity_toggle.sv ====
/*
  Activity blinker: square wave while busy, steady low when idle.
  Assumes busy is synchronous to i_mclk.
*/
`default_nettype none
`include "pinmux_regs.svh"

module activity_toggle
  import pinmux_pkg::*;
#(
  parameter int HALF_CYCLES = `ACT_HALF_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  act_if.blink lnk
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  act_state_t state_r;
  logic [CW-1:0] cnt_r;
  logic level_r;

  assign lnk.level = level_r;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ACT_IDLE;
      cnt_r <= '0;
      level_r <= 1'b0;
    end else if (lnk.ce) begin
      case (state_r)
        ACT_IDLE: begin
          cnt_r <= '0;
          level_r <= 1'b0;
          if (lnk.busy) begin
            state_r <= ACT_BLINK;
            // First edge at once so short bursts still show
            level_r <= 1'b1;
          end
        end
        ACT_BLINK: begin
          if (!lnk.busy) begin
            state_r <= ACT_IDLE;
            level_r <= 1'b0;
            cnt_r <= '0;
          end else if (cnt_r == LAST) begin
            cnt_r <= '0;
            level_r <= ~level_r;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: state_r <= ACT_IDLE;
      endcase
    end
  end
endmodule // activity_toggle

`default_nettype wire

// ==== verilog/uart_gpio_pin_function_control.sv ====
/*
  Pin function, pin type and USB status output control for the modem,
  GPIO and activity pins of a USB to UART bridge, with a small register
  port. Assumes core strobes and OTP image are on i_mclk; pad inputs are
  asynchronous. Pin order: 0 rts, 1 cts, 2 rs485, 3 txt, 4 rxt, 5 cd, 6 ri.
*/
// Implementation choices: the plain strobed port and the register addresses.
// Functional notes
// - Ring pin: GPIO, ring or wakeup input; resets to pulled-up input.
// - Carrier pin is GPIO or carrier detect; resets to pulled-up input.
// - Status output B offers the same conditions and polarity choice as A.
// - Status B defaults active low on suspend; software may reconfigure it.
// - Receive indicator pin toggles at about 10 Hz while data arrives.
// - Transmit indicator pin toggles at about 10 Hz while transmitting.
// - Half-duplex pin defaults to active-high push-pull enable, or GPIO.
// - Clear-to-send pin defaults to pulled-up active-low input, or GPIO.
// - RTS pin defaults to open-drain output; GPIO or half-duplex too.
// - Open-drain outputs carry a weak pull-up so released lines rest high.
// - GPIO and status pins take a pin type from register or OTP.
// - Enabled pull resistors stay on throughout USB suspend.
// - OTP pin settings apply after the next power-up and then persist.
// - Pull resistors are off during USB bus reset, back on afterwards.
// - Register pin settings are lost on power-on or USB bus reset.
// - Status conditions: bus reset, suspend, high current not yet allowed.
// - Unsafe current: high power, suspended or unconfigured; else suspended.
`default_nettype none
`include "pinmux_regs.svh"

module uart_gpio_pin_function_control
  import pinmux_pkg::*;
#(
  parameter int ACT_HALF_CYCLES = `ACT_HALF_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_usb_bus_reset,
  input wire logic i_usb_suspend,
  input wire logic i_usb_configured,
  input wire logic i_otp_valid,
  input wire logic [`NUM_PINS*`CFG_W-1:0] i_otp_pin_cfg,
  input wire logic [`CFG_W-1:0] i_otp_stat_a,
  input wire logic [`CFG_W-1:0] i_otp_stat_b,
  input wire logic [`CFG_W-1:0] i_otp_max_power,
  input wire logic i_rts_n,
  input wire logic i_rs485_en,
  input wire logic i_rx_active,
  input wire logic i_tx_active,
  input wire logic [`NUM_PINS-1:0] i_pin_in,
  output logic [`NUM_PINS-1:0] o_pin_out,
  output logic [`NUM_PINS-1:0] o_pin_oe_n,
  output logic [`NUM_PINS-1:0] o_pin_pu,
  output logic [`NUM_PINS-1:0] o_pin_pd,
  output logic [1:0] o_stat_out,
  output logic [1:0] o_stat_oe_n,
  output logic [1:0] o_stat_pu,
  output logic o_cts_n,
  output logic o_cd_n,
  output logic o_ring_indicator_n,
  output logic o_remote_wakeup_in_n
);
  localparam int P_RTS = 0;
  localparam int P_CTS = 1;
  localparam int P_RS485 = 2;
  localparam int P_TXT = 3;
  localparam int P_RXT = 4;
  localparam int P_CD = 5;
  localparam int P_RI = 6;

  // Returns {oe_n, out}; an open-drain pin only ever pulls low
  function automatic logic [1:0] pad_drive(input logic en, input logic val,
                                           input logic od);
    if (!en) pad_drive = 2'b11;
    else if (od) pad_drive = val ? 2'b11 : 2'b00;
    else pad_drive = {1'b0, val};
  endfunction

  function automatic logic [1:0] cfg_func(input cfg_t c);
    cfg_func = c[`CFG_FUNC_MSB:`CFG_FUNC_LSB];
  endfunction

  function automatic cfg_t default_pin(input int i);
    case (i)
      P_RTS: default_pin = `RST_PIN_RTS;
      P_CTS: default_pin = `RST_PIN_CTS;
      P_RS485: default_pin = `RST_PIN_RS485;
      P_TXT: default_pin = `RST_PIN_TXT;
      P_RXT: default_pin = `RST_PIN_RXT;
      P_CD: default_pin = `RST_PIN_CD;
      default: default_pin = `RST_PIN_RI;
    endcase
  endfunction

  // Boot image, captured once after power-on reset release
  cfg_t img_pin_r [`NUM_PINS];
  cfg_t img_stat_a_r, img_stat_b_r, img_max_power_r;
  logic boot_done_r;

  // Live (volatile) configuration
  cfg_t pin_cfg_r [`NUM_PINS];
  cfg_t stat_a_r, stat_b_r, max_power_r;

  pin_vec_t pin_meta_r, pin_sync_r;

  logic [`NUM_PINS-1:0] pin_out_nxt, pin_oe_n_nxt, pin_pu_nxt, pin_pd_nxt;
  logic [1:0] stat_out_nxt, stat_oe_n_nxt;
  logic [31:0] rdata_nxt;
  logic cond_unsafe, reload;
  logic [2:0] cond_vec;

  act_if tx_lnk ();
  act_if rx_lnk ();

  assign tx_lnk.busy = i_tx_active;
  assign tx_lnk.ce = i_ce;
  assign rx_lnk.busy = i_rx_active;
  assign rx_lnk.ce = i_ce;

  activity_toggle #(.HALF_CYCLES(ACT_HALF_CYCLES)) u_tx_blink (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .lnk(tx_lnk.blink)
  );

  activity_toggle #(.HALF_CYCLES(ACT_HALF_CYCLES)) u_rx_blink (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .lnk(rx_lnk.blink)
  );

  // Pad inputs are asynchronous: two flops before use
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_meta_r <= '1;
      pin_sync_r <= '1;
    end else if (i_ce) begin
      pin_meta_r <= i_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Later OTP writes do not reach the image until power cycles
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      boot_done_r <= 1'b0;
      img_stat_a_r <= `RST_STAT_A;
      img_stat_b_r <= `RST_STAT_B;
      img_max_power_r <= `RST_MAX_POWER;
      for (int i = 0; i < `NUM_PINS; i++) img_pin_r[i] <= default_pin(i);
    end else if (i_ce && !boot_done_r) begin
      boot_done_r <= 1'b1;
      if (i_otp_valid) begin
        img_stat_a_r <= i_otp_stat_a;
        img_stat_b_r <= i_otp_stat_b;
        img_max_power_r <= i_otp_max_power;
        for (int i = 0; i < `NUM_PINS; i++) begin
          img_pin_r[i] <= i_otp_pin_cfg[i*`CFG_W +: `CFG_W];
        end
      end
    end
  end

  // Reload from the image one cycle after boot capture and during bus reset
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      reload <= 1'b1;
    end else if (i_ce) begin
      reload <= !boot_done_r;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      stat_a_r <= `RST_STAT_A;
      stat_b_r <= `RST_STAT_B;
      max_power_r <= `RST_MAX_POWER;
      for (int i = 0; i < `NUM_PINS; i++) pin_cfg_r[i] <= default_pin(i);
    end else if (i_ce) begin
      if (reload || i_usb_bus_reset) begin
        stat_a_r <= img_stat_a_r;
        stat_b_r <= img_stat_b_r;
        max_power_r <= img_max_power_r;
        for (int i = 0; i < `NUM_PINS; i++) pin_cfg_r[i] <= img_pin_r[i];
      end else if (i_wr) begin
        for (int i = 0; i < `NUM_PINS; i++) begin
          if (i_addr == `OFS_PIN_CFG0 + 6'(4 * i)) begin
            pin_cfg_r[i] <= i_wdata[`CFG_W-1:0];
          end
        end
        if (i_addr == `OFS_STAT_A) stat_a_r <= i_wdata[`CFG_W-1:0];
        if (i_addr == `OFS_STAT_B) stat_b_r <= i_wdata[`CFG_W-1:0];
        if (i_addr == `OFS_MAX_POWER) max_power_r <= i_wdata[`CFG_W-1:0];
      end
    end
  end

  // Status conditions, indexed by the condition code
  always_comb begin
    if (max_power_r > `ONE_UNIT_LOAD) begin
      cond_unsafe = i_usb_suspend || !i_usb_configured;
    end else begin
      cond_unsafe = i_usb_suspend;
    end
    cond_vec = {cond_unsafe, i_usb_suspend, i_usb_bus_reset};
  end

  // Both status outputs share one path; only their config differs
  always_comb begin
    cfg_t sc;
    logic hit;
    logic lvl;
    sc = '0;
    hit = 1'b0;
    lvl = 1'b0;
    stat_out_nxt = 2'b11;
    stat_oe_n_nxt = 2'b11;
    for (int s = 0; s < 2; s++) begin
      sc = (s == 0) ? stat_a_r : stat_b_r;
      case (sc[`ST_COND_MSB:`ST_COND_LSB])
        `COND_BUS_RESET: hit = cond_vec[0];
        `COND_SUSPEND: hit = cond_vec[1];
        `COND_UNSAFE: hit = cond_vec[2];
        default: hit = 1'b0;
      endcase
      lvl = sc[`ST_ACT_HIGH] ? hit : !hit;
      {stat_oe_n_nxt[s], stat_out_nxt[s]} =
        pad_drive(1'b1, lvl, !sc[`ST_PUSH_PULL]);
    end
  end

  // Per-pin function mux
  always_comb begin
    logic en;
    logic val;
    logic od;
    logic [1:0] fn;
    en = 1'b0;
    val = 1'b1;
    od = 1'b0;
    fn = `FN_GPIO;
    for (int i = 0; i < `NUM_PINS; i++) begin
      fn = cfg_func(pin_cfg_r[i]);
      od = pin_cfg_r[i][`CFG_OD];
      en = pin_cfg_r[i][`CFG_DIR];
      val = pin_cfg_r[i][`CFG_OUT];
      if (fn != `FN_GPIO) begin
        case (i)
          P_RTS: begin
            en = 1'b1;
            val = (fn == `FN_ALT2) ? i_rs485_en : i_rts_n;
          end
          P_RS485: begin
            en = 1'b1;
            val = i_rs485_en;
          end
          P_TXT: begin
            en = 1'b1;
            val = tx_lnk.level;
          end
          P_RXT: begin
            en = 1'b1;
            val = rx_lnk.level;
          end
          default: en = 1'b0;
        endcase
      end
      {pin_oe_n_nxt[i], pin_out_nxt[i]} = pad_drive(en, val, od);
      // Pulls follow config, not suspend; bus reset drops them
      pin_pu_nxt[i] = !i_usb_bus_reset &&
        (pin_cfg_r[i][`CFG_PU] || (en && od));
      pin_pd_nxt[i] = !i_usb_bus_reset &&
        pin_cfg_r[i][`CFG_PD];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_out <= '1;
      o_pin_oe_n <= '1;
      o_pin_pu <= '0;
      o_pin_pd <= '0;
      o_stat_out <= 2'b11;
      o_stat_oe_n <= 2'b11;
      o_stat_pu <= 2'b00;
    end else if (i_ce) begin
      o_pin_out <= pin_out_nxt;
      o_pin_oe_n <= pin_oe_n_nxt;
      o_pin_pu <= pin_pu_nxt;
      o_pin_pd <= pin_pd_nxt;
      o_stat_out <= stat_out_nxt;
      o_stat_oe_n <= stat_oe_n_nxt;
      for (int s = 0; s < 2; s++) begin
        o_stat_pu[s] <= !i_usb_bus_reset &&
          !((s == 0) ? stat_a_r[`ST_PUSH_PULL]
                     : stat_b_r[`ST_PUSH_PULL]);
      end
    end
  end

  // Modem inputs to the core; inactive (high) unless the function is chosen
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cts_n <= 1'b1;
      o_cd_n <= 1'b1;
      o_ring_indicator_n <= 1'b1;
      o_remote_wakeup_in_n <= 1'b1;
    end else if (i_ce) begin
      o_cts_n <= (cfg_func(pin_cfg_r[P_CTS]) == `FN_ALT1) ?
                 pin_sync_r[P_CTS] : 1'b1;
      o_cd_n <= (cfg_func(pin_cfg_r[P_CD]) == `FN_ALT1) ?
                pin_sync_r[P_CD] : 1'b1;
      o_ring_indicator_n <= (cfg_func(pin_cfg_r[P_RI]) == `FN_ALT1) ?
                            pin_sync_r[P_RI] : 1'b1;
      o_remote_wakeup_in_n <= (cfg_func(pin_cfg_r[P_RI]) == `FN_ALT2) ?
                              pin_sync_r[P_RI] : 1'b1;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    for (int i = 0; i < `NUM_PINS; i++) begin
      if (i_addr == `OFS_PIN_CFG0 + 6'(4 * i)) begin
        rdata_nxt = {24'h00_0000, pin_cfg_r[i]};
      end
    end
    case (i_addr)
      `OFS_STAT_A: rdata_nxt = {24'h00_0000, stat_a_r};
      `OFS_STAT_B: rdata_nxt = {24'h00_0000, stat_b_r};
      `OFS_MAX_POWER: rdata_nxt = {24'h00_0000, max_power_r};
      `OFS_PIN_IN: rdata_nxt = {25'h000_0000, pin_sync_r};
      `OFS_USB_STATE: rdata_nxt = {26'h000_0000, tx_lnk.level,
        rx_lnk.level, cond_vec, boot_done_r};
      default: ;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rdata_nxt : 32'h0000_0000;
    end
  end
endmodule // uart_gpio_pin_function_control

`default_nettype wire

// ==== testbench/pinmux_asserts.sv ====
/* Port-level checker for the pin function control top.
   Assumes ACT_HALF_CYCLES of 4 and that the cts and activity pin settings
   keep their power-up values. */
`default_nettype none
`include "pinmux_regs.svh"
module pinmux_asserts #(
  parameter int ACT_HALF_CYCLES = 4
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [5:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_usb_bus_reset,
  input wire logic i_usb_suspend,
  input wire logic i_otp_valid,
  input wire logic i_rx_active,
  input wire logic i_tx_active,
  input wire logic [`NUM_PINS-1:0] i_pin_in,
  input wire logic [`NUM_PINS-1:0] o_pin_out,
  input wire logic [`NUM_PINS-1:0] o_pin_oe_n,
  input wire logic [`NUM_PINS-1:0] o_pin_pu,
  input wire logic [`NUM_PINS-1:0] o_pin_pd,
  input wire logic [1:0] o_stat_oe_n,
  input wire logic o_cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] boot_r;
  logic b_dflt_r;
  logic boot_done;
  assign boot_done = boot_r == 3'h7;
  // Boot wait covers image load and the input synchroniser depth
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) boot_r <= 3'h0;
    else if (!boot_done) boot_r <= boot_r + 3'h1;
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) b_dflt_r <= 1'h1;
    else if (i_usb_bus_reset) b_dflt_r <= 1'h1;
    else if (i_wr && i_addr == `OFS_STAT_B) b_dflt_r <= 1'h0;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  property p_rdata_zero;
    !$past(i_rd) |-> o_rdata == 32'h0;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero)
    else $error("read data left standing");
  property p_busrst_pulls;
    i_usb_bus_reset |=> o_pin_pu == 7'h00 && o_pin_pd == 7'h00;
  endproperty
  a_busrst_pulls: assert property (p_busrst_pulls)
    else $error("pulls active in bus reset");
  property p_susp_pulls;
    boot_done && $rose(i_usb_suspend) && !$past(i_wr) && !i_usb_bus_reset
      && !$past(i_usb_bus_reset) |=> $stable(o_pin_pu) && $stable(o_pin_pd);
  endproperty
  a_susp_pulls: assert property (p_susp_pulls)
    else $error("pulls changed on suspend");
  property p_tx_idle;
    boot_done && !$past(i_tx_active, 2) |-> !o_pin_out[3] && !o_pin_oe_n[3];
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("tx indicator not steady");
  property p_tx_blink;
    boot_done && $rose(i_tx_active) ##1 i_tx_active[*6] |-> !o_pin_out[3]
      && $past(o_pin_out[3]) && $past(o_pin_out[3], ACT_HALF_CYCLES)
      && !$past(o_pin_out[3], ACT_HALF_CYCLES + 1);
  endproperty
  a_tx_blink: assert property (p_tx_blink)
    else $error("tx indicator period wrong");
  property p_rx_start;
    boot_done && $rose(i_rx_active) ##1 i_rx_active[*2]
      |-> o_pin_out[4] && !o_pin_oe_n[4];
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("rx indicator did not start");
  property p_stat_b;
    boot_done && b_dflt_r && !i_otp_valid && !$past(i_usb_bus_reset)
      |-> o_stat_oe_n[1] == !$past(i_usb_suspend);
  endproperty
  a_stat_b: assert property (p_stat_b)
    else $error("status b default wrong");
  property p_cts;
    boot_done |-> o_cts_n == $past(i_pin_in[1], 3);
  endproperty
  a_cts: assert property (p_cts)
    else $error("cts does not follow pad");
  c_tx: cover property ($rose(i_tx_active));
  c_busrst: cover property ($fell(i_usb_bus_reset));
  c_susp: cover property ($rose(i_usb_suspend));
endmodule // pinmux_asserts
`default_nettype wire

// ==== testbench/pad_far_side.sv ====
/* Board side of the pads: external drivers, pulls and floating lines.
   Assumes pad controls from the pin function control top. */
`default_nettype none
module pad_far_side
  import pinmux_pkg::*;
(
  input wire logic i_mclk,
  input wire pin_vec_t i_pin_out,
  input wire pin_vec_t i_oe_n,
  input wire pin_vec_t i_pu,
  input wire pin_vec_t i_pd,
  input wire pin_vec_t i_ext_en,
  input wire pin_vec_t i_ext_val,
  output var pin_vec_t o_pad
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating line wanders so a stale value never reads as correct
  pin_vec_t float_r = 7'h55;
  always_ff @(posedge i_mclk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < $bits(pin_vec_t); i++) begin
      if (!i_oe_n[i]) o_pad[i] = i_pin_out[i];
      else if (i_ext_en[i]) o_pad[i] = i_ext_val[i];
      else if (i_pu[i]) o_pad[i] = 1'b1;
      else if (i_pd[i]) o_pad[i] = 1'b0;
      else o_pad[i] = float_r[i];
    end
  end
endmodule // pad_far_side
`default_nettype wire

// ==== testbench/uart_gpio_pin_function_control_tb.sv ====
/* Self-checking bench for the pin function control top.
   Assumes the pad model and checker files are compiled before it. */
`default_nettype none
`include "pinmux_regs.svh"
module uart_gpio_pin_function_control_tb;
  import pinmux_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 4;
  logic i_mclk, i_resetn, i_wr, i_rd, i_usb_bus_reset, i_usb_suspend;
  logic i_usb_configured, i_otp_valid, i_rts_n, i_rs485_en;
  logic i_rx_active, i_tx_active, o_cts_n, o_cd_n;
  logic o_ring_indicator_n, o_remote_wakeup_in_n;
  logic i_ce = 1'b1;
  logic [5:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [55:0] i_otp_pin_cfg;
  logic [7:0] i_otp_stat_a, i_otp_stat_b, i_otp_max_power;
  logic [1:0] o_stat_out, o_stat_oe_n, o_stat_pu, s;
  pin_vec_t i_pin_in, o_pin_out, o_pin_oe_n, o_pin_pu, o_pin_pd;
  pin_vec_t ext_en, ext_val;
  int dflt[7] = '{8'h11, 8'h21, 8'h01, 8'h01, 8'h01, 8'h20, 8'h20};
  int otp_m[7] = '{8'h11, 8'h21, 8'h01, 8'h01, 8'h01, 8'h20, 8'h0C};
  int cfg_m[7];
  int seed = 28;
  int r, mp, cb, mismatches, comparisons;
  bit v, otp_on;
  uart_gpio_pin_function_control #(.ACT_HALF_CYCLES(HALF))
    uart_gpio_pin_function_control_i (.i_mclk, .i_resetn, .i_ce, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_usb_bus_reset, .i_usb_suspend,
    .i_usb_configured, .i_otp_valid, .i_otp_pin_cfg,
    .i_otp_stat_a, .i_otp_stat_b,
    .i_otp_max_power, .i_rts_n, .i_rs485_en, .i_rx_active,
    .i_tx_active, .i_pin_in, .o_pin_out, .o_pin_oe_n, .o_pin_pu, .o_pin_pd,
    .o_stat_out, .o_stat_oe_n, .o_stat_pu, .o_cts_n, .o_cd_n,
    .o_ring_indicator_n, .o_remote_wakeup_in_n);
  pad_far_side pad_far_side_i (.i_mclk, .i_pin_out(o_pin_out),
    .i_oe_n(o_pin_oe_n), .i_pu(o_pin_pu), .i_pd(o_pin_pd), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pad(i_pin_in));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    if (!i_usb_bus_reset && a < `OFS_STAT_A) cfg_m[a[4:2]] = d[7:0];
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    tick(1);
    i_wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    tick(1);
    i_rd <= 1'b0;
    check(o_rdata, exp);
    tick(1);
  endtask
  task automatic rd_all();
    for (int i = 0; i < 7; i++) rd(6'(4 * i), cfg_m[i]);
  endtask
  // Volatile settings fall back to the image taken at power-up
  task automatic reload();
    for (int i = 0; i < 7; i++) cfg_m[i] = otp_on ? otp_m[i] : dflt[i];
  endtask
  task automatic por();
    i_resetn <= 1'b0;
    tick(6);
    otp_on = i_otp_valid;
    reload();
    i_resetn <= 1'b1;
    tick(8);
  endtask
  function automatic logic [1:0] stat_exp(int c, bit su, bit co, int m);
    bit a;
    a = c[1:0] == 0 ? 1'b0 : c[1:0] == 1 ? su : su || (m > 8'h32 && !co);
    a = c[2] ? a : !a;
    return c[3] ? {1'b0, a} : {a, a};
  endfunction
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    close_out();
  end
  initial begin
    {i_resetn, i_wr, i_rd, i_usb_bus_reset, i_usb_suspend} = 5'h00;
    {i_usb_configured, i_otp_valid, i_rx_active, i_tx_active} = 4'h0;
    {i_rts_n, i_rs485_en, i_addr, i_wdata, ext_en, ext_val} = '0;
    i_otp_pin_cfg = 56'h0;
    i_otp_stat_b = `RST_STAT_B;
    i_otp_stat_a = `RST_STAT_A;
    i_otp_max_power = `RST_MAX_POWER;
    por();
    rd_all();
    rd(`OFS_STAT_A, 32'h05);
    rd(`OFS_STAT_B, 32'h01);
    rd(6'h30, 32'h0);
    rd(`OFS_USB_STATE, 32'h01);
    for (int f = 0; f < 3; f++) begin
      r = $random(seed);
      v = r[0];
      wr(6'h18, f);
      wr(6'h14, f == 2 ? 0 : f);
      ext_en <= 7'h60;
      ext_val <= {v, v, 5'h00};
      tick(4);
      check(o_ring_indicator_n, f == 1 ? v : 1'b1);
      check(o_remote_wakeup_in_n, f == 2 ? v : 1'b1);
      check(o_cd_n, f == 1 ? v : 1'b1);
      rd(`OFS_PIN_IN, {v, v, 5'h02});
    end
    ext_en <= 7'h00;
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      v = r[0];
      i_rts_n <= v;
      i_rs485_en <= !v;
      tick(3);
      check({o_pin_oe_n[0], o_pin_pu[0]}, v ? 2'h3 : 2'h1);
      check({o_pin_oe_n[2], o_pin_out[2]}, {1'b0, !v});
      wr(6'h08, 8'h04 | (v << 3));
      tick(1);
      check({o_pin_oe_n[2], o_pin_out[2]}, {1'b0, v});
      wr(6'h08, 8'h01);
      wr(6'h00, 8'h02);
      check({o_pin_oe_n[0], o_pin_out[0]}, {1'b0, !v});
      wr(6'h00, 8'h11);
    end
    i_usb_suspend <= 1'b1;
    tick(2);
    check(o_stat_oe_n[1], 1'b0);
    for (int n = 0; n < 12; n++) begin
      r = $random(seed);
      mp = (n / 3) % 2 ? 8'h33 : 8'h32;
      cb = n % 3 | (r[2] << 2);
      wr(`OFS_MAX_POWER, mp);
      wr(`OFS_STAT_A, 8'h0C | n % 3);
      wr(`OFS_STAT_B, cb);
      i_usb_suspend <= r[0];
      i_usb_configured <= r[1];
      tick(2);
      s = stat_exp(8'h0C | n % 3, r[0], r[1], mp);
      check({o_stat_oe_n[0], o_stat_out[0]}, s);
      s = stat_exp(cb, r[0], r[1], mp);
      check({o_stat_oe_n[1], o_stat_out[1]}, s);
      check(o_stat_pu, 2'h2);
    end
    i_usb_suspend <= 1'b0;
    wr(6'h14, 8'h40);
    tick(1);
    i_usb_suspend <= 1'b1;
    tick(3);
    check({o_pin_pd[5], o_pin_pu[5]}, 2'h2);
    i_usb_bus_reset <= 1'b1;
    tick(2);
    check({o_stat_pu, o_pin_pu, o_pin_pd}, 16'h0);
    reload();
    wr(6'h14, 8'h40);
    i_usb_bus_reset <= 1'b0;
    tick(2);
    check({o_pin_pd[5], o_pin_pu[5]}, 2'h1);
    rd_all();
    i_usb_suspend <= 1'b0;
    for (int d = 0; d < 2; d++) begin
      if (d) i_rx_active <= 1'b1;
      else i_tx_active <= 1'b1;
      for (int j = 1; j < 20; j++) begin
        tick(1);
        v = j >= 2 && ((j - 2) / HALF) % 2 == 0;
        check(o_pin_out[3 + d], v);
      end
      i_rx_active <= 1'b0;
      i_tx_active <= 1'b0;
      tick(3);
      repeat (6) begin
        tick(1);
        check(o_pin_out[3 + d], 1'b0);
      end
    end
    i_otp_pin_cfg <= 56'h0C_20_01_01_01_21_11;
    i_otp_stat_b <= 8'h0C;
    i_otp_stat_a <= 8'h0D;
    i_otp_max_power <= 8'h33;
    i_otp_valid <= 1'b1;
    tick(3);
    check(o_pin_oe_n[6], 1'b1);
    por();
    check({o_pin_oe_n[6], o_pin_out[6]}, 2'h1);
    rd(`OFS_STAT_A, 32'h0D);
    rd(`OFS_STAT_B, 32'h0C);
    rd(`OFS_MAX_POWER, 32'h33);
    i_usb_bus_reset <= 1'b1;
    tick(2);
    check(o_stat_out[1], 1'b1);
    i_usb_bus_reset <= 1'b0;
    tick(2);
    rd_all();
    wr(6'h18, 8'h20);
    por();
    rd_all();
    close_out();
  end
endmodule // uart_gpio_pin_function_control_tb
bind uart_gpio_pin_function_control pinmux_asserts #(
  .ACT_HALF_CYCLES(ACT_HALF_CYCLES)) pinmux_asserts_i (.i_mclk, .i_resetn,
  .i_addr, .i_wr, .i_rd, .o_rdata, .i_usb_bus_reset, .i_usb_suspend,
  .i_otp_valid, .i_rx_active, .i_tx_active, .i_pin_in, .o_pin_out,
  .o_pin_oe_n, .o_pin_pu, .o_pin_pd, .o_stat_oe_n, .o_cts_n);
`default_nettype wire
